// file: inc/standby_params.svh
// constants for the standby mode controller
// assumes inclusion by bare name from the package and the design file
`ifndef STANDBY_PARAMS_SVH
`define STANDBY_PARAMS_SVH

// oscillator enable vector bit positions
`define OSC_CERAMIC_BIT     0
`define OSC_LOW_RC_BIT      1
`define OSC_MID_RC_BIT      2
`define OSC_VAR_RC_BIT      3
`define OSC_CRYSTAL_BIT     4
`define OSC_COUNT           5

// software oscillator settings after reset: everything stopped
`define OSC_RESET_VALUE     5'h00

// mode request encodings
`define REQ_NONE            2'h0
`define REQ_PAUSE           2'h1
`define REQ_DEEP            2'h2
`define REQ_XTAL            2'h3

`endif

// file: inc/standby_pkg.sv
// types for the standby mode controller
// assumes the params header is on the include path
`include "standby_params.svh"

package standby_pkg;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_PAUSE = 2'b01,
        ST_DEEP  = 2'b10,
        ST_XTAL  = 2'b11
    } mode_type;

    typedef logic [`OSC_COUNT-1:0] osc_type;

endpackage : standby_pkg

// file: verification/standby_cpu_model.sv
// cpu side partner: issues standby requests on behalf of the bench
// assumes the bench asks for one request at a time on the controller clock
`timescale 1ns/10ps
`include "standby_params.svh"

module standby_cpu_model (
    input  wire logic       CLK,
    input  wire logic       RSTN,
    input  wire logic       CPU_RUN,
    input  wire logic       REQ_GO,
    input  wire logic [1:0] REQ_CODE,
    output logic            MODE_REQ_VALID,
    output logic [1:0]      MODE_REQ
);
// ----------------------------------------
// request issue
// ----------------------------------------
// a halted cpu executes nothing, so it cannot ask for standby
always_ff @(posedge CLK) begin
    MODE_REQ_VALID <= REQ_GO & CPU_RUN & RSTN;
end

// code wanders when not qualified so the controller cannot lean on it
always_ff @(posedge CLK) begin
    if (!RSTN) begin
        MODE_REQ <= `REQ_NONE;
    end else begin
        MODE_REQ <= REQ_GO ? REQ_CODE : ~MODE_REQ;
    end
end
endmodule : standby_cpu_model

// file: verification/standby_mode_control_bench.sv
// self-checking bench for the standby mode controller
// assumes the cpu model in its own file; wake sources are levels
`timescale 1ns/10ps
`include "standby_params.svh"

module standby_mode_control_bench;
import standby_pkg::*;
logic clk = 1'b0;
logic rstn = 1'b0;
logic req_go = 1'b0;
logic [1:0] req_code = 2'h0;
logic [4:0] osc_sw = 5'h00;
logic wdt_on = 1'b0, wdt_stby = 1'b0, lvl0 = 1'b0, lvl1 = 1'b0, xsel = 1'b0;
// src: 0 any irq,1-4 ext zero/one/two/four,5 port0,6 base timer,7 pin,8 lvd,9 wdt
logic [9:0] src = 10'h000;
logic cpu_run, periph_run, bt_run, full_reset, wake, mvalid;
logic [4:0] osc_en;
logic [1:0] mode, mreq;
int err_count = 0;
int checks_done = 0;

always #2.5 clk = ~clk;

standby_cpu_model cpu_u (.CLK(clk), .RSTN(rstn), .CPU_RUN(cpu_run), .REQ_GO(req_go),
    .REQ_CODE(req_code), .MODE_REQ_VALID(mvalid), .MODE_REQ(mreq));

standby_mode_control dut_u (.CLK(clk), .RSTN(rstn), .MODE_REQ(mreq),
    .MODE_REQ_VALID(mvalid), .OSC_SW_EN(osc_sw), .WDT_LOW_RC_EN(wdt_on),
    .WDT_LOW_RC_STBY_EN(wdt_stby), .RESET_PIN_N(~src[7]), .LVD_RESET(src[8]),
    .WDT_RESET(src[9]), .ANY_IRQ(src[0]), .EXT_IRQ_ZERO(src[1]), .EXT_IRQ_ONE(src[2]),
    .EXT_IRQ_TWO(src[3]), .EXT_IRQ_FOUR(src[4]), .EXT_IRQ_ZERO_LEVEL(lvl0),
    .EXT_IRQ_ONE_LEVEL(lvl1), .PORT0_IRQ(src[5]), .BASE_TIMER_IRQ(src[6]),
    .BASE_TIMER_XTAL_SEL(xsel), .CPU_RUN(cpu_run), .PERIPH_RUN(periph_run),
    .BASE_TIMER_RUN(bt_run), .OSC_EN(osc_en), .MODE(mode), .FULL_RESET(full_reset),
    .WAKE(wake));

// ----------------------------------------
// compare and drive helpers
// ----------------------------------------
task automatic chk_bit(input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
        err_count++;
        $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
endtask : chk_bit

task automatic chk_vec(input logic [4:0] exp, input logic [4:0] got);
    checks_done++;
    if (got !== exp) begin
        err_count++;
        $display("BAD %0t value %h expected %h", $time, got, exp);
    end
endtask : chk_vec

task automatic enter(input mode_type m);
    @(posedge clk) req_go <= 1'b1;
    req_code <= m;
    @(posedge clk) req_go <= 1'b0;
    @(posedge clk);
    #1;
    chk_vec({3'h0, m}, {3'h0, mode});
endtask : enter

// raise one source; a brief lvd reset then returns the block to run
task automatic trial(input mode_type m, input int s, input logic wk, input logic rs);
    @(posedge clk) src[s] <= 1'b1;
    @(posedge clk);
    #1;
    chk_vec({3'h0, (wk | rs) ? ST_RUN : m}, {3'h0, mode});
    chk_bit(wk, wake);
    chk_bit(rs, full_reset);
    @(posedge clk) src <= 10'h100;
    @(posedge clk) src <= 10'h000;
    repeat (2) @(posedge clk);
endtask : trial

// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic s_pause();
    @(posedge clk) osc_sw <= 5'h15;
    wdt_on <= 1'b1;
    enter(ST_PAUSE);
    chk_bit(1'b0, cpu_run);
    chk_bit(1'b1, periph_run);
    chk_vec(5'h17, osc_en);
    trial(ST_PAUSE, 0, 1'b1, 1'b0);
endtask : s_pause

task automatic s_deep();
    @(posedge clk) osc_sw <= 5'h1F;
    enter(ST_DEEP);
    chk_bit(1'b0, cpu_run);
    chk_bit(1'b0, periph_run | bt_run);
    chk_vec(5'h00, osc_en);
    @(posedge clk) wdt_stby <= 1'b1;
    @(posedge clk);
    #1;
    chk_vec(5'h02, osc_en);
    trial(ST_DEEP, 1, 1'b0, 1'b0);
    enter(ST_DEEP);
    trial(ST_DEEP, 2, 1'b0, 1'b0);
    enter(ST_DEEP);
    trial(ST_DEEP, 6, 1'b0, 1'b0);
    @(posedge clk) lvl0 <= 1'b1;
    lvl1 <= 1'b1;
    for (int s = 1; s <= 5; s++) begin
        enter(ST_DEEP);
        trial(ST_DEEP, s, 1'b1, 1'b0);
    end
endtask : s_deep

task automatic s_xtal();
    @(posedge clk) wdt_stby <= 1'b0;
    enter(ST_XTAL);
    chk_bit(1'b0, cpu_run | periph_run);
    chk_bit(1'b1, bt_run);
    chk_vec(5'h10, osc_en);
    @(posedge clk) osc_sw <= 5'h0F;
    @(posedge clk);
    #1;
    chk_vec(5'h10, osc_en);
    trial(ST_XTAL, 6, 1'b0, 1'b0);
    @(posedge clk) xsel <= 1'b1;
    enter(ST_XTAL);
    chk_vec(5'h00, osc_en);
    trial(ST_XTAL, 6, 1'b1, 1'b0);
    for (int s = 1; s <= 5; s++) begin
        enter(ST_XTAL);
        trial(ST_XTAL, s, 1'b1, 1'b0);
    end
endtask : s_xtal

task automatic s_reset();
    for (int m = 1; m <= 3; m++) begin
        for (int s = 7; s <= 9; s++) begin
            enter(mode_type'(m));
            trial(mode_type'(m), s, 1'b0, 1'b1);
        end
    end
    // a stop request while a reset source stands must be refused
    @(posedge clk) src <= 10'h200;
    req_go <= 1'b1;
    req_code <= `REQ_DEEP;
    @(posedge clk) req_go <= 1'b0;
    @(posedge clk);
    #1;
    chk_vec({3'h0, ST_RUN}, {3'h0, mode});
    chk_bit(1'b1, full_reset);
    enter(ST_RUN);
    chk_bit(1'b1, cpu_run);
    @(posedge clk) src <= 10'h000;
endtask : s_reset

task automatic give_verdict();
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask : give_verdict

initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    s_pause();
    s_deep();
    s_xtal();
    s_reset();
    give_verdict();
end
endmodule : standby_mode_control_bench

// file: verilog/standby_mode_control.sv
// standby mode controller: cpu pause, deep stop and crystal-keeping stop
// assumes all inputs synchronous to CLK and interrupt requests held until serviced
//
// Operation
// - In the cpu pause mode instruction execution stops while peripherals keep running.
// - Entering the cpu pause mode leaves every oscillator but the low-speed rc as software last set it; the low-speed rc follows software or the watchdog.
// - The cpu pause mode ends on reset pin low, low-voltage reset, watchdog reset or any interrupt.
// - In the deep stop mode both instruction execution and all peripherals are suspended.
// - The deep stop mode stops the ceramic, the mid and var rc and the crystal oscillators; the low-speed rc follows the watchdog.
// - The watchdog timer controls the low-speed rc oscillator directly, also in standby.
// - The deep stop mode ends on reset pin, low-voltage, watchdog, external or port 0 wakes.
// - An interrupt on external inputs two or four, or on zero or one set for level detection, releases the deep stop mode.
// - External inputs zero and one wake a stop mode only while set for level detection.
// - A port 0 interrupt releases either stop mode.
// - The crystal-keeping stop suspends execution and all peripherals but the base timer.
// - The crystal-keeping stop stops the ceramic and the mid and var rc oscillators; the low-speed rc follows the watchdog.
// - The crystal-keeping stop keeps the crystal oscillator as it was at entry.
// - The crystal-keeping stop ends on every deep stop wake plus a base timer interrupt with crystal clock selected.
// - A base timer interrupt wakes the crystal-keeping stop only with crystal clock selected.
`timescale 1ns/10ps
`include "standby_params.svh"

module standby_mode_control
    import standby_pkg::*;
(
    input  wire logic                  CLK,
    input  wire logic                  RSTN,
    input  wire logic [1:0]            MODE_REQ,
    input  wire logic                  MODE_REQ_VALID,
    input  wire logic [`OSC_COUNT-1:0] OSC_SW_EN,
    input  wire logic                  WDT_LOW_RC_EN,
    input  wire logic                  WDT_LOW_RC_STBY_EN,
    input  wire logic                  RESET_PIN_N,
    input  wire logic                  LVD_RESET,
    input  wire logic                  WDT_RESET,
    input  wire logic                  ANY_IRQ,
    input  wire logic                  EXT_IRQ_ZERO,
    input  wire logic                  EXT_IRQ_ONE,
    input  wire logic                  EXT_IRQ_TWO,
    input  wire logic                  EXT_IRQ_FOUR,
    input  wire logic                  EXT_IRQ_ZERO_LEVEL,
    input  wire logic                  EXT_IRQ_ONE_LEVEL,
    input  wire logic                  PORT0_IRQ,
    input  wire logic                  BASE_TIMER_IRQ,
    input  wire logic                  BASE_TIMER_XTAL_SEL,
    output logic                       CPU_RUN,
    output logic                       PERIPH_RUN,
    output logic                       BASE_TIMER_RUN,
    output logic [`OSC_COUNT-1:0]      OSC_EN,
    output logic [1:0]                 MODE,
    output logic                       FULL_RESET,
    output logic                       WAKE
);

    // ----------------------------------------------------------------
    // wake decoding
    // ----------------------------------------------------------------
    mode_type mode_r;
    mode_type mode_nxt;
    logic     xtal_keep_r;
    logic     sys_reset;
    logic     stop_wake;
    logic     wake_now;

    // edge-configured inputs zero and one cannot wake a stop mode
    function automatic logic stop_irq_wake(
        input logic z,
        input logic z_lvl,
        input logic o,
        input logic o_lvl,
        input logic t,
        input logic f,
        input logic p0);
        stop_irq_wake = (z & z_lvl) | (o & o_lvl) | t | f | p0;
    endfunction : stop_irq_wake

    assign sys_reset = ~RESET_PIN_N | LVD_RESET | WDT_RESET;
    assign stop_wake = stop_irq_wake(EXT_IRQ_ZERO, EXT_IRQ_ZERO_LEVEL,
                                     EXT_IRQ_ONE, EXT_IRQ_ONE_LEVEL,
                                     EXT_IRQ_TWO, EXT_IRQ_FOUR,
                                     PORT0_IRQ);

    always_comb begin
        wake_now = 1'b0;
        case (mode_r)
            ST_PAUSE: wake_now = sys_reset | ANY_IRQ;
            ST_DEEP:  wake_now = sys_reset | stop_wake;
            ST_XTAL:  wake_now = sys_reset | stop_wake
                                 | (BASE_TIMER_IRQ & BASE_TIMER_XTAL_SEL);
            default:  wake_now = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // mode state machine
    // ----------------------------------------------------------------
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            ST_RUN: begin
                if (MODE_REQ_VALID && !sys_reset) begin
                    if (MODE_REQ == `REQ_PAUSE) begin
                        mode_nxt = ST_PAUSE;
                    end else if (MODE_REQ == `REQ_DEEP) begin
                        mode_nxt = ST_DEEP;
                    end else if (MODE_REQ == `REQ_XTAL) begin
                        mode_nxt = ST_XTAL;
                    end
                end
            end
            default: begin
                if (wake_now) begin
                    mode_nxt = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            mode_r <= ST_RUN;
        end else if (sys_reset) begin
            mode_r <= ST_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // crystal state captured on entry so a software change during the mode is ignored
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            xtal_keep_r <= 1'b0;
        end else if (mode_r == ST_RUN && mode_nxt == ST_XTAL) begin
            xtal_keep_r <= OSC_SW_EN[`OSC_CRYSTAL_BIT];
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            FULL_RESET <= 1'b1;
            WAKE       <= 1'b0;
        end else begin
            // reset wake restarts the core instead of resuming
            FULL_RESET <= sys_reset;
            WAKE       <= (mode_r != ST_RUN) && wake_now && !sys_reset;
        end
    end

    always_comb begin
        CPU_RUN        = (mode_r == ST_RUN);
        PERIPH_RUN     = (mode_r == ST_RUN) || (mode_r == ST_PAUSE);
        BASE_TIMER_RUN = PERIPH_RUN || (mode_r == ST_XTAL);
        MODE           = mode_r;
        OSC_EN         = OSC_SW_EN;
        if (mode_r == ST_DEEP || mode_r == ST_XTAL) begin
            OSC_EN[`OSC_CERAMIC_BIT] = 1'b0;
            OSC_EN[`OSC_MID_RC_BIT]  = 1'b0;
            OSC_EN[`OSC_VAR_RC_BIT]  = 1'b0;
            OSC_EN[`OSC_LOW_RC_BIT]  = 1'b0;
            OSC_EN[`OSC_CRYSTAL_BIT] = (mode_r == ST_XTAL) ? xtal_keep_r : 1'b0;
        end
        // watchdog keeps its own say over the low-speed rc in any mode
        if (mode_r == ST_RUN || mode_r == ST_PAUSE) begin
            OSC_EN[`OSC_LOW_RC_BIT] = OSC_SW_EN[`OSC_LOW_RC_BIT] | WDT_LOW_RC_EN;
        end else begin
            OSC_EN[`OSC_LOW_RC_BIT] = WDT_LOW_RC_STBY_EN;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    pause_no_cpu_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_PAUSE) |-> (!CPU_RUN && PERIPH_RUN))
        else $error("cpu runs or peripherals stop in pause");

    pause_osc_keep_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_PAUSE) |-> (OSC_EN[`OSC_CRYSTAL_BIT] == OSC_SW_EN[`OSC_CRYSTAL_BIT]
                                  && OSC_EN[`OSC_CERAMIC_BIT] == OSC_SW_EN[`OSC_CERAMIC_BIT]))
        else $error("pause altered an oscillator");

    pause_exit_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_PAUSE && (ANY_IRQ || sys_reset)) |=> (mode_r == ST_RUN))
        else $error("pause not left on wake");

    deep_halt_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_DEEP) |-> (!CPU_RUN && !PERIPH_RUN && !BASE_TIMER_RUN))
        else $error("deep stop left logic running");

    deep_osc_off_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_DEEP) |-> (OSC_EN[`OSC_CERAMIC_BIT] == 1'b0
                                 && OSC_EN[`OSC_CRYSTAL_BIT] == 1'b0))
        else $error("oscillator runs in deep stop");

    low_rc_wdt_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_DEEP) |-> (OSC_EN[`OSC_LOW_RC_BIT] == WDT_LOW_RC_STBY_EN))
        else $error("low rc not under watchdog in standby");

    edge_no_wake_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_DEEP && !sys_reset && !EXT_IRQ_TWO && !EXT_IRQ_FOUR && !PORT0_IRQ
         && !EXT_IRQ_ZERO_LEVEL && !EXT_IRQ_ONE_LEVEL) |=> (mode_r == ST_DEEP))
        else $error("edge-configured input woke stop");

    xtal_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_XTAL && $past(mode_r) == ST_XTAL)
        |-> (OSC_EN[`OSC_CRYSTAL_BIT] == $past(OSC_EN[`OSC_CRYSTAL_BIT])))
        else $error("crystal state changed in crystal stop");

    base_wake_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_XTAL && BASE_TIMER_IRQ && BASE_TIMER_XTAL_SEL) |=> (mode_r == ST_RUN))
        else $error("base timer did not wake crystal stop");

    reset_full_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r != ST_RUN && sys_reset) |=> (FULL_RESET && !WAKE && mode_r == ST_RUN))
        else $error("reset wake resumed instead of reset");

    pause_bt_run_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_PAUSE) |-> BASE_TIMER_RUN)
        else $error("base timer stopped in pause");

    pause_rc_keep_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_PAUSE) |-> (OSC_EN[`OSC_MID_RC_BIT] == OSC_SW_EN[`OSC_MID_RC_BIT]
                                  && OSC_EN[`OSC_VAR_RC_BIT] == OSC_SW_EN[`OSC_VAR_RC_BIT]))
        else $error("pause altered an rc oscillator");

    pause_stay_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_PAUSE && !ANY_IRQ && !sys_reset) |=> (mode_r == ST_PAUSE))
        else $error("pause left without a wake");

    pause_entry_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_RUN && MODE_REQ_VALID && MODE_REQ == `REQ_PAUSE && !sys_reset)
        |=> (mode_r == ST_PAUSE))
        else $error("pause request not taken");

    deep_entry_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_RUN && MODE_REQ_VALID && MODE_REQ == `REQ_DEEP && !sys_reset)
        |=> (mode_r == ST_DEEP && !CPU_RUN && !PERIPH_RUN))
        else $error("deep stop request not taken");

    deep_rc_off_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_DEEP) |-> (OSC_EN[`OSC_MID_RC_BIT] == 1'b0
                                 && OSC_EN[`OSC_VAR_RC_BIT] == 1'b0))
        else $error("rc oscillator runs in deep stop");

    deep_exit_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_DEEP && (!RESET_PIN_N || LVD_RESET || WDT_RESET || PORT0_IRQ
                               || EXT_IRQ_TWO || EXT_IRQ_FOUR)) |=> (mode_r == ST_RUN))
        else $error("deep stop not left on wake");

    deep_base_ignore_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_DEEP && !sys_reset && !stop_wake) |=> (mode_r == ST_DEEP))
        else $error("deep stop left without a wake");

    deep_ext_wake_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_DEEP && ((EXT_IRQ_ZERO && EXT_IRQ_ZERO_LEVEL)
                               || (EXT_IRQ_ONE && EXT_IRQ_ONE_LEVEL)
                               || EXT_IRQ_TWO || EXT_IRQ_FOUR)) |=> (mode_r == ST_RUN))
        else $error("external input did not wake deep stop");

    port0_wake_a: assert property (@(posedge CLK) disable iff (!RSTN)
        ((mode_r == ST_DEEP || mode_r == ST_XTAL) && PORT0_IRQ) |=> (mode_r == ST_RUN))
        else $error("port 0 input did not wake stop");

    xtal_halt_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_XTAL) |-> (!CPU_RUN && !PERIPH_RUN && BASE_TIMER_RUN))
        else $error("crystal stop runs the wrong logic");

    xtal_osc_off_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_XTAL) |-> (OSC_EN[`OSC_CERAMIC_BIT] == 1'b0
                                 && OSC_EN[`OSC_MID_RC_BIT] == 1'b0
                                 && OSC_EN[`OSC_VAR_RC_BIT] == 1'b0))
        else $error("oscillator runs in crystal stop");

    xtal_entry_keep_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_RUN && MODE_REQ_VALID && MODE_REQ == `REQ_XTAL && !sys_reset)
        |=> (mode_r == ST_XTAL
             && OSC_EN[`OSC_CRYSTAL_BIT] == $past(OSC_SW_EN[`OSC_CRYSTAL_BIT])))
        else $error("crystal state not kept at entry");

    xtal_low_rc_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_XTAL) |-> (OSC_EN[`OSC_LOW_RC_BIT] == WDT_LOW_RC_STBY_EN))
        else $error("low rc not under watchdog in crystal stop");

    pause_low_rc_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_PAUSE) |-> (OSC_EN[`OSC_LOW_RC_BIT]
                                  == (OSC_SW_EN[`OSC_LOW_RC_BIT] | WDT_LOW_RC_EN)))
        else $error("low rc lost watchdog control in pause");

    xtal_exit_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_XTAL && (!RESET_PIN_N || LVD_RESET || WDT_RESET || PORT0_IRQ
                               || EXT_IRQ_TWO || EXT_IRQ_FOUR)) |=> (mode_r == ST_RUN))
        else $error("crystal stop not left on wake");

    xtal_level_wake_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_XTAL && ((EXT_IRQ_ZERO && EXT_IRQ_ZERO_LEVEL)
                               || (EXT_IRQ_ONE && EXT_IRQ_ONE_LEVEL))) |=> (mode_r == ST_RUN))
        else $error("level input did not wake crystal stop");

    base_no_wake_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (mode_r == ST_XTAL && !sys_reset && !stop_wake && !BASE_TIMER_XTAL_SEL)
        |=> (mode_r == ST_XTAL))
        else $error("base timer woke without crystal clock");

    pin_wake_a: assert property (@(posedge CLK) disable iff (!RSTN)
        ((mode_r == ST_DEEP || mode_r == ST_XTAL) && (EXT_IRQ_TWO
         || (EXT_IRQ_ZERO && EXT_IRQ_ZERO_LEVEL) || (EXT_IRQ_ONE && EXT_IRQ_ONE_LEVEL)))
        |=> (mode_r == ST_RUN))
        else $error("wake pin did not end stop");

    reset_to_run_a: assert property (@(posedge CLK) disable iff (!RSTN)
        sys_reset |=> (mode_r == ST_RUN && FULL_RESET))
        else $error("system reset did not force run");

    wake_resume_a: assert property (@(posedge CLK) disable iff (!RSTN)
        WAKE |-> !FULL_RESET)
        else $error("resume and full reset together");

    wake_pulse_a: assert property (@(posedge CLK) disable iff (!RSTN)
        WAKE |=> !WAKE)
        else $error("wake longer than one cycle");

endmodule : standby_mode_control
